// [hdl/dps_params.svh]
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH
// Clock period and the time units that the tick chain is built from.
`define DPS_CLK_NS 8
`define DPS_MS_NS 1000000
`define DPS_MS_CYC (`DPS_MS_NS / `DPS_CLK_NS)
`define DPS_TENTH_MS 7'h63
`define DPS_SEC_TENTHS 4'h9
`define DPS_FLASH_TENTHS 3'h4
// Fixed limits, in seconds, tenths of percent or volts.
`define DPS_STALL_MAX_S 7'h3C
`define DPS_SC_WAIT_S 4'hA
`define DPS_HW_LIMIT 12'h8FC
`define DPS_SW_OFF 12'hBB8
`define DPS_NOM_220 11'h137
`define DPS_NOM_380 11'h219
`define DPS_MARGIN_220 11'h017
`define DPS_MARGIN_380 11'h034
`define DPS_PCT_DIV 22'h0003E8
`define DPS_HIST_DEPTH 5'h1E
// Register indices.
`define DPS_A_CTRL 5'h00
`define DPS_A_STALL 5'h01
`define DPS_A_INPL 5'h02
`define DPS_A_OUTTH 5'h03
`define DPS_A_OUTT 5'h04
`define DPS_A_TRIES 5'h05
`define DPS_A_IVAL 5'h06
`define DPS_A_CLDLY 5'h07
`define DPS_A_SWLIM 5'h08
`define DPS_A_HSEL 5'h09
`define DPS_A_STAT 5'h0A
`define DPS_A_HFLT 5'h0B
`define DPS_A_HOF 5'h0C
`define DPS_A_HSF 5'h0D
`define DPS_A_HCUR 5'h0E
`define DPS_A_HBUS 5'h0F
`define DPS_A_HRUN 5'h10
`define DPS_A_HHRS 5'h11
`define DPS_A_HTMP 5'h12
`define DPS_A_HCNT 5'h13
// Reset values and write ranges.
`define DPS_R_CTRL 16'h0071
`define DPS_R_STALL 16'h0578
`define DPS_R_INPL 16'h000A
`define DPS_R_OUTTH 16'h0001
`define DPS_R_OUTT 16'h0014
`define DPS_R_IVAL 16'h0032
`define DPS_R_CLDLY 16'h0032
`define DPS_R_SWLIM 16'h05DC
`define DPS_STALL_MIN 16'h044C
`define DPS_STALL_MAX 16'h05DC
`define DPS_INPL_MIN 16'h0002
`define DPS_INPL_MAX 16'h00FF
`define DPS_PCT_MAX 16'h0064
`define DPS_OUTT_MAX 16'h00C8
`define DPS_TRIES_MAX 16'h000A
`define DPS_IVAL_MIN 16'h0014
`define DPS_SWLIM_MIN 16'h03E8
`endif

// [hdl/dps_pkg.sv]
package dps_pkg;
  // Stored fault causes.
  typedef enum logic [4:0] {
    FLT_NONE = 5'h00, FLT_UV_BUS = 5'h01, FLT_UV_CTL = 5'h02,
    FLT_CHARGE = 5'h03, FLT_OVI_ACC = 5'h04, FLT_OVI_DEC = 5'h05,
    FLT_OVI_CON = 5'h06, FLT_OVV_ACC = 5'h07, FLT_OVV_DEC = 5'h08,
    FLT_OVV_CON = 5'h09, FLT_EARTH = 5'h0A, FLT_HEATSINK = 5'h0B,
    FLT_MOTOR_OL = 5'h0C, FLT_DRIVE_OL = 5'h0D, FLT_SHORT = 5'h0E,
    FLT_EXT_COMM = 5'h0F, FLT_EXT_TERM = 5'h10, FLT_IN_PHASE = 5'h11,
    FLT_OUT_PHASE = 5'h12
  } dps_fault_e;
  // Running state codes.
  typedef enum logic [1:0] {
    RUN_STOP = 2'h0, RUN_ACC = 2'h1, RUN_DEC = 2'h2, RUN_CONST = 2'h3
  } dps_run_e;
  // Protection sequencer states.
  typedef enum logic [1:0] {
    PS_OK = 2'h0, PS_RETRY = 2'h1, PS_FAULT_LAMP = 2'h2
  } dps_prot_e;
  // Live drive measurements.
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] set_freq;
    logic [15:0] current;
    logic [9:0] bus_volts;
    dps_run_e run_state;
    logic [15:0] on_hours;
    logic [11:0] igbt_temp;
  } dps_meas_s;
  // One history entry.
  typedef struct packed {
    dps_fault_e fault;
    dps_meas_s meas;
  } dps_snap_s;
endpackage : dps_pkg

// [hdl/dps_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"
module dps_top
  import dps_pkg::*;
#(
  parameter int MS_CYC = `DPS_MS_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire dps_meas_s meas,
  input wire logic fault_valid,
  input wire dps_fault_e fault_code,
  input wire logic manual_reset,
  input wire logic run_cmd,
  input wire logic channel_switch,
  input wire logic in_phase_raw,
  input wire logic [6:0] out_imbalance,
  input wire logic analog_in1_bad,
  input wire logic analog_in2_bad,
  output logic pwm_block,
  output logic freq_hold,
  output logic brake_on,
  output logic fault_lamp,
  output logic analog_in1_alarm,
  output logic analog_in2_alarm,
  output logic run_enable,
  output logic current_limit_decel,
  output logic hw_limit_hit,
  output logic restart_pulse
);

  // Volts for a percentage (tenths) of the nominal bus.
  function automatic logic [10:0] pct_volts(input logic [10:0] nom,
                                            input logic [15:0] pct);
    logic [26:0] prod;
    prod = 27'(nom) * 27'(pct);
    return 11'(prod / 27'(`DPS_PCT_DIV));
  endfunction : pct_volts

  // Slot of the k-th newest entry given the next write slot.
  function automatic logic [4:0] hist_slot(input logic [4:0] wp,
                                           input logic [4:0] k);
    logic [5:0] s;
    s = 6'(wp) + 6'(`DPS_HIST_DEPTH) - 6'(k);
    if (s >= 6'(`DPS_HIST_DEPTH)) begin
      s = s - 6'(`DPS_HIST_DEPTH);
    end
    return s[4:0];
  endfunction : hist_slot

  // Settings written by software.
  logic [15:0] ctrl_ff, stall_pt_ff, in_time_ff, out_thr_ff;
  logic [15:0] out_time_ff, tries_ff, ival_ff, cl_dly_ff, sw_lim_ff;
  logic [15:0] hsel_ff;
  // Tick chain: 1 ms, 100 ms, 1 s.
  logic [16:0] ms_cnt_ff;
  logic [6:0] tenth_cnt_ff;
  logic [3:0] sec_cnt_ff;
  logic ms_tick_ff, tenth_tick_ff, sec_tick_ff;
  // Protection state.
  dps_prot_e prot_ff;
  dps_fault_e last_fault_ff;
  logic [3:0] tries_used_ff;
  logic [7:0] ival_cnt_ff;
  logic [3:0] sc_cnt_ff;
  logic [6:0] stall_cnt_ff;
  logic [7:0] inpl_cnt_ff;
  logic [7:0] outpl_cnt_ff;
  logic [7:0] cl_cnt_ff;
  logic [2:0] flash_cnt_ff;
  logic need_fresh_ff;
  // History store.
  dps_snap_s hist_ff [0:29];
  logic [4:0] wp_ff, hcnt_ff;

  // Combinational helpers.
  logic [10:0] nom_v, stall_v, brake_v;
  logic stall_now, sw_over, hw_over, new_fault, auto_ok;
  dps_fault_e nxt_fault;
  dps_snap_s shown;

  // Control bits.
  logic stall_sel, ana_disp, pu_lock, cs_lock, hw_en, hwpl_en, sup380;
  assign stall_sel = ctrl_ff[0];
  assign ana_disp = ctrl_ff[1];
  assign pu_lock = ctrl_ff[2];
  assign cs_lock = ctrl_ff[3];
  assign hw_en = ctrl_ff[4];
  assign hwpl_en = ctrl_ff[5];
  assign sup380 = ctrl_ff[6];

  // Bus thresholds from supply class and stall point.
  always_comb begin
    nom_v = sup380 ? `DPS_NOM_380 : `DPS_NOM_220;
    stall_v = pct_volts(nom_v, stall_pt_ff);
    brake_v = stall_v - (sup380 ? `DPS_MARGIN_380 : `DPS_MARGIN_220);
    stall_now = stall_sel && (prot_ff == PS_OK) &&
                (meas.run_state == RUN_DEC) &&
                (11'(meas.bus_volts) >= stall_v);
    sw_over = (sw_lim_ff[11:0] != `DPS_SW_OFF) &&
              (meas.current[11:0] >= sw_lim_ff[11:0]);
    hw_over = hw_en && (meas.current[11:0] >= `DPS_HW_LIMIT);
  end

  // Fault source arbitration; the external report has priority.
  always_comb begin
    nxt_fault = FLT_NONE;
    if (fault_valid && fault_code != FLT_NONE) begin
      nxt_fault = fault_code;
    end else if (stall_now && sec_tick_ff &&
                 stall_cnt_ff >= `DPS_STALL_MAX_S) begin
      nxt_fault = FLT_OVV_DEC;
    end else if (hwpl_en && in_phase_raw && sec_tick_ff &&
                 16'(inpl_cnt_ff) + 16'h0001 >= in_time_ff) begin
      nxt_fault = FLT_IN_PHASE;
    end else if (out_imbalance > out_thr_ff[6:0] && tenth_tick_ff &&
                 16'(outpl_cnt_ff) + 16'h0001 >= out_time_ff) begin
      nxt_fault = FLT_OUT_PHASE;
    end
    new_fault = (nxt_fault != FLT_NONE) && (prot_ff == PS_OK);
    auto_ok = (nxt_fault inside {FLT_OVI_ACC, FLT_OVI_DEC, FLT_OVI_CON,
               FLT_OVV_ACC, FLT_OVV_DEC, FLT_OVV_CON, FLT_EARTH});
  end

  // Tick chain for all long timers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff <= 17'h00000;
      tenth_cnt_ff <= 7'h00;
      sec_cnt_ff <= 4'h0;
      ms_tick_ff <= 1'b0;
      tenth_tick_ff <= 1'b0;
      sec_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= (ms_cnt_ff == 17'(MS_CYC - 1));
      ms_cnt_ff <= (ms_cnt_ff == 17'(MS_CYC - 1)) ? 17'h00000
                   : ms_cnt_ff + 17'h00001;
      tenth_tick_ff <= 1'b0;
      sec_tick_ff <= 1'b0;
      if (ms_tick_ff) begin
        // A tenth elapses every hundred milliseconds.
        if (tenth_cnt_ff == `DPS_TENTH_MS) begin
          tenth_cnt_ff <= 7'h00;
          tenth_tick_ff <= 1'b1;
          if (sec_cnt_ff == `DPS_SEC_TENTHS) begin
            sec_cnt_ff <= 4'h0;
            sec_tick_ff <= 1'b1;
          end else begin
            sec_cnt_ff <= sec_cnt_ff + 4'h1;
          end
        end else begin
          tenth_cnt_ff <= tenth_cnt_ff + 7'h01;
        end
      end
    end
  end

  // Software register writes; out-of-range values are ignored.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `DPS_R_CTRL;
      stall_pt_ff <= `DPS_R_STALL;
      in_time_ff <= `DPS_R_INPL;
      out_thr_ff <= `DPS_R_OUTTH;
      out_time_ff <= `DPS_R_OUTT;
      tries_ff <= 16'h0000;
      ival_ff <= `DPS_R_IVAL;
      cl_dly_ff <= `DPS_R_CLDLY;
      sw_lim_ff <= `DPS_R_SWLIM;
      hsel_ff <= 16'h0001;
    end else if (reg_wr) begin
      case (reg_addr)
        `DPS_A_CTRL: ctrl_ff <= {9'h000, reg_wdata[6:0]};
        `DPS_A_STALL: begin
          if (reg_wdata >= `DPS_STALL_MIN && reg_wdata <= `DPS_STALL_MAX)
          begin
            stall_pt_ff <= reg_wdata;
          end
        end
        `DPS_A_INPL: begin
          if (reg_wdata >= `DPS_INPL_MIN && reg_wdata <= `DPS_INPL_MAX)
          begin
            in_time_ff <= reg_wdata;
          end
        end
        `DPS_A_OUTTH: begin
          if (reg_wdata <= `DPS_PCT_MAX) out_thr_ff <= reg_wdata;
        end
        `DPS_A_OUTT: begin
          if (reg_wdata <= `DPS_OUTT_MAX) out_time_ff <= reg_wdata;
        end
        `DPS_A_TRIES: begin
          if (reg_wdata <= `DPS_TRIES_MAX) tries_ff <= reg_wdata;
        end
        `DPS_A_IVAL: begin
          if (reg_wdata >= `DPS_IVAL_MIN && reg_wdata <= `DPS_OUTT_MAX)
          begin
            ival_ff <= reg_wdata;
          end
        end
        `DPS_A_CLDLY: begin
          if (reg_wdata <= `DPS_OUTT_MAX) cl_dly_ff <= reg_wdata;
        end
        `DPS_A_SWLIM: begin
          if (reg_wdata >= `DPS_SWLIM_MIN &&
              reg_wdata <= 16'(`DPS_SW_OFF)) begin
            sw_lim_ff <= reg_wdata;
          end
        end
        `DPS_A_HSEL: begin
          if (reg_wdata <= 16'(hcnt_ff)) hsel_ff <= reg_wdata;
        end
        default: ;
      endcase
    end
  end

  // Persistence timers for stall, phase loss and current limit.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_ff <= 7'h00;
      inpl_cnt_ff <= 8'h00;
      outpl_cnt_ff <= 8'h00;
      cl_cnt_ff <= 8'h00;
    end else begin
      // Continuous stall seconds; any break restarts the count.
      if (!stall_now) stall_cnt_ff <= 7'h00;
      else if (sec_tick_ff && stall_cnt_ff < `DPS_STALL_MAX_S)
        stall_cnt_ff <= stall_cnt_ff + 7'h01;
      if (!(hwpl_en && in_phase_raw)) inpl_cnt_ff <= 8'h00;
      else if (sec_tick_ff && inpl_cnt_ff != 8'hFF)
        inpl_cnt_ff <= inpl_cnt_ff + 8'h01;
      if (out_imbalance <= out_thr_ff[6:0]) outpl_cnt_ff <= 8'h00;
      else if (tenth_tick_ff && outpl_cnt_ff != 8'hFF)
        outpl_cnt_ff <= outpl_cnt_ff + 8'h01;
      if (!sw_over) cl_cnt_ff <= 8'h00;
      else if (ms_tick_ff && cl_cnt_ff != 8'hFF)
        cl_cnt_ff <= cl_cnt_ff + 8'h01;
    end
  end

  // Protection sequencer: retry, fault_lamp and manual reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prot_ff <= PS_OK;
      last_fault_ff <= FLT_NONE;
      tries_used_ff <= 4'h0;
      ival_cnt_ff <= 8'h00;
      sc_cnt_ff <= 4'h0;
      restart_pulse <= 1'b0;
    end else begin
      restart_pulse <= 1'b0;
      case (prot_ff)
        PS_OK: begin
          if (new_fault) begin
            last_fault_ff <= nxt_fault;
            ival_cnt_ff <= 8'h00;
            sc_cnt_ff <= 4'h0;
            // Zero tries leaves auto reset off entirely.
            if (auto_ok && 16'(tries_used_ff) < tries_ff)
              prot_ff <= PS_RETRY;
            else
              prot_ff <= PS_FAULT_LAMP;
          end
        end
        PS_RETRY: begin
          // Output stays blocked at zero speed through the interval.
          if (tenth_tick_ff) ival_cnt_ff <= ival_cnt_ff + 8'h01;
          if (16'(ival_cnt_ff) >= ival_ff) begin
            tries_used_ff <= tries_used_ff + 4'h1;
            prot_ff <= PS_OK;
            restart_pulse <= 1'b1;
          end
        end
        PS_FAULT_LAMP: begin
          if (sec_tick_ff && sc_cnt_ff < `DPS_SC_WAIT_S)
            sc_cnt_ff <= sc_cnt_ff + 4'h1;
          // A short fault refuses manual reset for the wait time.
          if (manual_reset && (last_fault_ff != FLT_SHORT ||
                               sc_cnt_ff >= `DPS_SC_WAIT_S)) begin
            prot_ff <= PS_OK;
            tries_used_ff <= 4'h0;
          end
        end
        default: prot_ff <= PS_FAULT_LAMP;
      endcase
    end
  end

  // Snapshot capture into a circular store of thirty entries.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= 5'h00;
      hcnt_ff <= 5'h00;
      for (int i = 0; i < 30; i++) begin
        hist_ff[i] <= '0;
      end
    end else if (new_fault) begin
      hist_ff[wp_ff] <= '{fault: nxt_fault, meas: meas};
      // The oldest slot is reused once the store is full.
      wp_ff <= (wp_ff == `DPS_HIST_DEPTH - 5'h01) ? 5'h00
               : wp_ff + 5'h01;
      if (hcnt_ff != `DPS_HIST_DEPTH) hcnt_ff <= hcnt_ff + 5'h01;
    end
  end

  // Run interlocks for power-up and command channel changes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      need_fresh_ff <= 1'b1;
      run_enable <= 1'b0;
    end else begin
      if (cs_lock && channel_switch)
        need_fresh_ff <= 1'b1;
      else if (!run_cmd || (!pu_lock && !cs_lock))
        need_fresh_ff <= 1'b0;
      run_enable <= run_cmd && !need_fresh_ff && prot_ff == PS_OK &&
                    !(cs_lock && channel_switch);
    end
  end

  // Drive-facing protection outputs.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwm_block <= 1'b1;
      freq_hold <= 1'b0;
      brake_on <= 1'b0;
      current_limit_decel <= 1'b0;
      hw_limit_hit <= 1'b0;
      analog_in1_alarm <= 1'b0;
      analog_in2_alarm <= 1'b0;
    end else begin
      pwm_block <= new_fault || prot_ff != PS_OK;
      freq_hold <= stall_now && !new_fault;
      brake_on <= 11'(meas.bus_volts) >= brake_v;
      current_limit_decel <= sw_over &&
                             16'(cl_cnt_ff) >= cl_dly_ff;
      hw_limit_hit <= hw_over;
      analog_in1_alarm <= ana_disp && analog_in1_bad;
      analog_in2_alarm <= ana_disp && analog_in2_bad;
    end
  end

  // Fault lamp flashes at one hertz while output is blocked by a fault.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_ff <= 3'h0;
      fault_lamp <= 1'b0;
    end else if (prot_ff == PS_OK) begin
      flash_cnt_ff <= 3'h0;
      fault_lamp <= 1'b0;
    end else if (tenth_tick_ff) begin
      if (flash_cnt_ff == `DPS_FLASH_TENTHS) begin
        flash_cnt_ff <= 3'h0;
        fault_lamp <= !fault_lamp;
      end else begin
        flash_cnt_ff <= flash_cnt_ff + 3'h1;
      end
    end
  end

  // Displayed entry; none or an empty store shows a blank entry.
  always_comb begin
    shown = '0;
    if (hsel_ff != 16'h0000 && 16'(hcnt_ff) >= hsel_ff) begin
      shown = hist_ff[hist_slot(wp_ff, hsel_ff[4:0])];
    end
  end

  // Register reads answer in the following cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `DPS_A_CTRL: reg_rdata <= ctrl_ff;
        `DPS_A_STALL: reg_rdata <= stall_pt_ff;
        `DPS_A_INPL: reg_rdata <= in_time_ff;
        `DPS_A_OUTTH: reg_rdata <= out_thr_ff;
        `DPS_A_OUTT: reg_rdata <= out_time_ff;
        `DPS_A_TRIES: reg_rdata <= tries_ff;
        `DPS_A_IVAL: reg_rdata <= ival_ff;
        `DPS_A_CLDLY: reg_rdata <= cl_dly_ff;
        `DPS_A_SWLIM: reg_rdata <= sw_lim_ff;
        `DPS_A_HSEL: reg_rdata <= hsel_ff;
        `DPS_A_STAT: reg_rdata <= {prot_ff, stall_now, need_fresh_ff,
                                   sw_over, hw_over, 1'b0,
                                   last_fault_ff, tries_used_ff};
        `DPS_A_HFLT: reg_rdata <= {11'h000, shown.fault};
        `DPS_A_HOF: reg_rdata <= shown.meas.out_freq;
        `DPS_A_HSF: reg_rdata <= shown.meas.set_freq;
        `DPS_A_HCUR: reg_rdata <= shown.meas.current;
        `DPS_A_HBUS: reg_rdata <= {6'h00, shown.meas.bus_volts};
        `DPS_A_HRUN: reg_rdata <= {14'h0000, shown.meas.run_state};
        `DPS_A_HHRS: reg_rdata <= shown.meas.on_hours;
        `DPS_A_HTMP: reg_rdata <= {4'h0, shown.meas.igbt_temp};
        `DPS_A_HCNT: reg_rdata <= {11'h000, hcnt_ff};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : dps_top
`default_nettype wire

// [verification/dps_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Power stage and motor: reports what the bench asks of the bus,
// ramp and current, one cycle late like a sampled measurement.
module dps_drive_model
  import dps_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] bus_set,
  input wire dps_run_e run_set,
  input wire logic [15:0] cur_set,
  output dps_meas_s meas
);
  // Hours advance every cycle so that each snapshot differs.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meas <= '0;
    end else begin
      meas.bus_volts <= bus_set;
      meas.run_state <= run_set;
      meas.current <= cur_set;
      meas.on_hours <= meas.on_hours + 16'h0001;
      meas.out_freq <= (run_set == RUN_STOP) ? 16'h0000 : 16'h1388;
      meas.set_freq <= 16'h1388;
      meas.igbt_temp <= 12'h1F4;
    end
  end
endmodule : dps_drive_model
`default_nettype wire

// [verification/dps_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Ties each protection output except current_limit_decel, analog_in2_alarm and run_enable to the input condition that caused it.
module dps_top_monitor
  import dps_pkg::*;
#(
  parameter int MS_CYC = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire dps_meas_s meas,
  input wire logic fault_valid,
  input wire dps_fault_e fault_code,
  input wire logic manual_reset,
  input wire logic analog_in1_bad,
  input wire logic pwm_block,
  input wire logic freq_hold,
  input wire logic brake_on,
  input wire logic fault_lamp,
  input wire logic analog_in1_alarm,
  input wire logic hw_limit_hit,
  input wire logic restart_pulse
);
  // All checks share the system clock and its reset.
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // A retry interval ends with one pulse and the output is freed next.
  sequence s_retry_end;
    restart_pulse ##1 !pwm_block;
  endsequence
  a_fault_blocks: assert property (fault_valid && !pwm_block &&
    fault_code != FLT_NONE |=> pwm_block)
    else $error("fault did not block output");
  a_retry_release: assert property (restart_pulse |->
    pwm_block ##0 s_retry_end)
    else $error("retry end did not release output");
  a_pulse_single: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse longer than one cycle");
  a_lamp_quiet: assert property (!pwm_block |-> !fault_lamp)
    else $error("fault lamp lit without a fault");
  a_release_cause: assert property ($fell(pwm_block) |-> !$past(rst_n, 2) ||
    $past(restart_pulse) || $past(manual_reset) ||
    $past(manual_reset, 2) || $past(manual_reset, 3))
    else $error("output freed without reset or retry");
  a_hold_decel: assert property (freq_hold |->
    $past(meas.run_state) == RUN_DEC)
    else $error("frequency held outside deceleration");
  a_hw_limit: assert property (hw_limit_hit |->
    $past(meas.current) >= 16'h08FC)
    else $error("hardware limit below its fixed point");
  a_alarm_cause: assert property (analog_in1_alarm |->
    $past(analog_in1_bad))
    else $error("analog alarm without bad signal");
  a_brake_floor: assert property (brake_on |->
    $past(meas.bus_volts) >= 10'h13F)
    else $error("braking below the lowest threshold");
endmodule : dps_top_monitor
bind dps_top dps_top_monitor #(.MS_CYC(MS_CYC)) u_mon (.clock(clock),
  .rst_n(rst_n), .meas(meas), .fault_valid(fault_valid),
  .fault_code(fault_code), .manual_reset(manual_reset),
  .analog_in1_bad(analog_in1_bad), .pwm_block(pwm_block),
  .freq_hold(freq_hold), .brake_on(brake_on), .fault_lamp(fault_lamp),
  .analog_in1_alarm(analog_in1_alarm), .hw_limit_hit(hw_limit_hit),
  .restart_pulse(restart_pulse));
`default_nettype wire

// [verification/drive_protection_supervisor_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
// Self-checking bench for the protection supervisor.
module drive_protection_supervisor_tb_top
  import dps_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fault_valid = 1'b0;
  dps_fault_e fault_code = FLT_NONE;
  logic manual_reset = 1'b0;
  logic run_cmd = 1'b0;
  logic channel_switch = 1'b0;
  logic [1:0] bad = 2'h0;
  logic ipl = 1'b0;
  logic [6:0] imb = 7'h00;
  logic [9:0] bus_set = 10'h1F4;
  dps_run_e run_set = RUN_CONST;
  logic [15:0] cur_set = 16'h0100;
  logic [15:0] reg_rdata;
  dps_meas_s meas;
  logic pwm_block, freq_hold, brake_on, fault_lamp, run_enable, l;
  logic current_limit_decel, hw_limit_hit, restart_pulse;
  logic [1:0] alarm;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 55044;
  int n;
  int b;
  dps_fault_e c;
  // Reset values, then writes with the value each should leave behind.
  localparam logic [4:0] RA [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
    5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h13, 5'h1F};
  localparam logic [15:0] RV [12] = '{16'h0071, 16'h0578, 16'h000A,
    16'h0001, 16'h0014, 16'h0000, 16'h0032, 16'h0032, 16'h05DC,
    16'h0001, 16'h0000, 16'h0000};
  localparam logic [4:0] WA [7] = '{5'h01, 5'h01, 5'h01, 5'h05, 5'h08,
    5'h08, 5'h09};
  localparam logic [15:0] WV [7] = '{16'h044B, 16'h05DD, 16'h044C,
    16'h000B, 16'h03E7, 16'h0BB8, 16'h0005};
  localparam logic [15:0] WE [7] = '{16'h0578, 16'h0578, 16'h044C,
    16'h0000, 16'h05DC, 16'h0BB8, 16'h0001};

  always #4 clock = ~clock;

  dps_drive_model u_drive (.clock(clock), .rst_n(rst_n),
    .bus_set(bus_set), .run_set(run_set), .cur_set(cur_set), .meas(meas));
  dps_top #(.MS_CYC(1)) DUT (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
    .fault_valid(fault_valid), .fault_code(fault_code),
    .manual_reset(manual_reset), .run_cmd(run_cmd),
    .channel_switch(channel_switch), .in_phase_raw(ipl),
    .out_imbalance(imb), .analog_in1_bad(bad[0]),
    .analog_in2_bad(bad[1]), .pwm_block(pwm_block),
    .freq_hold(freq_hold), .brake_on(brake_on), .fault_lamp(fault_lamp),
    .analog_in1_alarm(alarm[0]), .analog_in2_alarm(alarm[1]),
    .run_enable(run_enable), .current_limit_decel(current_limit_decel),
    .hw_limit_hit(hw_limit_hit), .restart_pulse(restart_pulse));

  // Stall point in volts less a margin, truncated like the hardware.
  function automatic int thr(input int nom, input int pct, input int m);
    return nom * pct / 1000 - m;
  endfunction : thr
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd_chk
  task automatic drv(input int bv, input dps_run_e rs, input int cv);
    @(posedge clock);
    bus_set <= 10'(bv);
    run_set <= rs;
    cur_set <= 16'(cv);
    cyc(5);
  endtask : drv
  task automatic fault(input dps_fault_e f);
    @(posedge clock);
    fault_valid <= 1'b1;
    fault_code <= f;
    @(posedge clock);
    fault_valid <= 1'b0;
    #1;
  endtask : fault
  task automatic mreset();
    @(posedge clock);
    manual_reset <= 1'b1;
    @(posedge clock);
    manual_reset <= 1'b0;
    cyc(3);
  endtask : mreset
  task automatic pulse_cmd(input logic sw);
    @(posedge clock);
    channel_switch <= sw;
    run_cmd <= sw;
    @(posedge clock);
    channel_switch <= 1'b0;
    run_cmd <= 1'b1;
    cyc(4);
  endtask : pulse_cmd
  task automatic end_of_test();
    $display("errors %0d in %0d compares", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Cuts a hang short at about twice the expected run.
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) rd_chk(RA[i], RV[i]);
    for (int i = 0; i < 7; i++) begin
      wr(WA[i], WV[i]);
      rd_chk(WA[i], WE[i]);
    end
    wr(5'h01, 16'h0578);
    drv(500, RUN_CONST, 16'h0640);
    cyc(70);
    `CHK(current_limit_decel, 1'b0)
    wr(5'h08, 16'h05DC);
    cyc(20);
    `CHK(current_limit_decel, 1'b0)
    cyc(50);
    `CHK(current_limit_decel, 1'b1)
    drv(500, RUN_CONST, 16'h0900);
    `CHK(hw_limit_hit, 1'b1)
    drv(500, RUN_CONST, 16'h08FB);
    `CHK(hw_limit_hit, 1'b0)
    wr(5'h00, 16'h0061);
    drv(500, RUN_CONST, 16'h0900);
    `CHK(hw_limit_hit, 1'b0)
    wr(5'h00, 16'h0071);
    // Random bus levels around the braking and stall points.
    for (int i = 0; i < 24; i++) begin
      b = 680 + (($random(seed)) & 255) % 100;
      drv(b, RUN_DEC, 16'h0100);
      n = thr(537, 1400, 52);
      if (b < n - 2 || b > n + 2) `CHK(brake_on, 1'(b >= n))
      n = thr(537, 1400, 0);
      if (b < n - 2 || b > n + 2) `CHK(freq_hold, 1'(b >= n))
    end
    drv(780, RUN_ACC, 16'h0100);
    `CHK(freq_hold, 1'b0)
    wr(5'h00, 16'h0070);
    drv(780, RUN_DEC, 16'h0100);
    `CHK(freq_hold, 1'b0)
    wr(5'h00, 16'h0031);
    drv(thr(311, 1400, 23) + 8, RUN_CONST, 16'h0100);
    `CHK(brake_on, 1'b1)
    drv(thr(311, 1400, 23) - 7, RUN_CONST, 16'h0100);
    `CHK(brake_on, 1'b0)
    wr(5'h00, 16'h0071);
    drv(500, RUN_CONST, 16'h0100);
    @(posedge clock) bad <= 2'h3;
    cyc(4);
    `CHK(alarm, 2'h0)
    wr(5'h00, 16'h0073);
    cyc(4);
    `CHK(alarm, 2'h3)
    wr(5'h00, 16'h0079);
    bad <= 2'h0;
    pulse_cmd(1'b0);
    `CHK(run_enable, 1'b1)
    pulse_cmd(1'b1);
    `CHK(run_enable, 1'b0)
    pulse_cmd(1'b0);
    `CHK(run_enable, 1'b1)
    wr(5'h00, 16'h0071);
    fault(FLT_OVI_ACC);
    `CHK(pwm_block, 1'b1)
    l = fault_lamp;
    cyc(500);
    `CHK(fault_lamp, ~l)
    `CHK(pwm_block, 1'b1)
    rd_chk(5'h13, 16'h0001);
    rd_chk(5'h0B, 16'h0004);
    rd_chk(5'h0F, 16'h01F4);
    rd_chk(5'h10, 16'h0003);
    mreset();
    `CHK(pwm_block, 1'b0)
    wr(5'h05, 16'h0001);
    fault(FLT_OVV_DEC);
    n = 0;
    while (restart_pulse !== 1'b1 && n < 6000) begin
      cyc(1);
      n++;
    end
    `CHK(1'(n > 4900 && n < 5100), 1'b1)
    cyc(1);
    `CHK(pwm_block, 1'b0)
    mreset();
    fault(FLT_HEATSINK);
    cyc(2500);
    `CHK(pwm_block, 1'b1)
    mreset();
    fault(FLT_SHORT);
    cyc(200);
    mreset();
    `CHK(pwm_block, 1'b1)
    cyc(10500);
    mreset();
    `CHK(pwm_block, 1'b0)
    wr(5'h09, 16'h0002);
    rd_chk(5'h0B, 16'h000B);
    wr(5'h09, 16'h0000);
    rd_chk(5'h0B, 16'h0000);
    wr(5'h05, 16'h0000);
    // Random manual-reset causes fill the history past its depth.
    for (int i = 0; i < 28; i++) begin
      n = $random(seed);
      c = dps_fault_e'(5'(1 + (n & 255) % 13));
      fault(c);
      mreset();
    end
    rd_chk(5'h13, 16'h001E);
    wr(5'h09, 16'h0001);
    rd_chk(5'h0B, 16'(c));
    wr(5'h09, 16'h001E);
    rd_chk(5'h0B, 16'h000B);
    wr(5'h02, 16'h0002);
    ipl <= 1'b1;
    cyc(2100);
    `CHK(pwm_block, 1'b1)
    @(posedge clock) ipl <= 1'b0;
    mreset();
    @(posedge clock) imb <= 7'h02;
    cyc(2100);
    `CHK(pwm_block, 1'b1)
    end_of_test();
  end
endmodule : drive_protection_supervisor_tb_top
`default_nettype wire
